// ==== rtl/abstx_map.svh ====
`ifndef ABSTX_MAP_SVH
`define ABSTX_MAP_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ABSTX_OFF_CTRL      8'h00
`define ABSTX_OFF_STAT      8'h04
`define ABSTX_OFF_POS       8'h08
`define ABSTX_OFF_HOME      8'h0c
`define ABSTX_OFF_EVT       8'h10
`define ABSTX_OFF_MASK      8'h14

// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define ABSTX_CTRL_DEN      0
`define ABSTX_CTRL_HMODE    1
`define ABSTX_CTRL_HSTART   2
`define ABSTX_CTRL_ARST     3
`define ABSTX_CTRL_MOVE     4
`define ABSTX_CTRL_TLIM     5
`define ABSTX_CTRL_W        6

// ---------------------------------------------------------------
// Status fields
// ---------------------------------------------------------------
`define ABSTX_ST_BUSY       0
`define ABSTX_ST_VALID      1
`define ABSTX_ST_INPOS      2
`define ABSTX_ST_ZSPD       3
`define ABSTX_ST_TLIM       4
`define ABSTX_ST_COMM       5
`define ABSTX_ST_CSUM       6
`define ABSTX_ST_ALARM      7
`define ABSTX_ST_HOMEOK     8
`define ABSTX_ST_W          9

// ---------------------------------------------------------------
// Event fields
// ---------------------------------------------------------------
`define ABSTX_EV_DONE       0
`define ABSTX_EV_COMM       1
`define ABSTX_EV_CSUM       2
`define ABSTX_EV_ALARM      3
`define ABSTX_EV_HOME       4
`define ABSTX_EV_W          5

// ---------------------------------------------------------------
// Reset values and protocol figures
// ---------------------------------------------------------------
`define ABSTX_CTRL_RST      6'h00
`define ABSTX_MASK_RST      5'h00
`define ABSTX_LAST_PAIR     5'h12
`define ABSTX_MAX_FAILS     3'h4
`define ABSTX_REV_NEEDED    2'h2

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ABSTX_CLK_KHZ       40000
`define ABSTX_XFER_TMO_MS   5000
`define ABSTX_REQ_TMO_MS    1000
`define ABSTX_RTS_TMO_MS    1000
`define ABSTX_CLR_PULSE_US  100
`define ABSTX_XFER_TMO_CYC  (`ABSTX_XFER_TMO_MS * `ABSTX_CLK_KHZ)
`define ABSTX_REQ_TMO_CYC   (`ABSTX_REQ_TMO_MS * `ABSTX_CLK_KHZ)
`define ABSTX_RTS_TMO_CYC   (`ABSTX_RTS_TMO_MS * `ABSTX_CLK_KHZ)
`define ABSTX_CLR_CYC       ((`ABSTX_CLR_PULSE_US * `ABSTX_CLK_KHZ) / 1000)
`endif

// ==== rtl/abstx_pkg.sv ====
package abstx_pkg;
  typedef enum logic [2:0] {
    ABSTX_IDLE     = 3'b000,
    ABSTX_WAIT_RDY = 3'b001,
    ABSTX_REQ      = 3'b010,
    ABSTX_ACK      = 3'b011,
    ABSTX_CHECK    = 3'b100,
    ABSTX_RETRY    = 3'b101,
    ABSTX_DONE     = 3'b110
  } abstx_state_t;
endpackage

// ==== rtl/abstx_tmo.sv ====
`timescale 1ns/1ps
// Saturating watchdog: clears while run is low, flags once limit is reached
module abstx_tmo (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        run,
  input  wire logic [31:0] limit,
  output logic             expired
);
  logic [31:0] count_q;
  logic [31:0] count_d;

  assign count_d = (count_q == limit) ? count_q : count_q + 32'h0000_0001;
  assign expired = run && (count_q == limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 32'h0000_0000;
    end else if (!run) begin
      count_q <= 32'h0000_0000;
    end else begin
      count_q <= count_d;
    end
  end
endmodule

// ==== rtl/abstx_ctrl.sv ====
`timescale 1ns/1ps
`include "abstx_map.svh"
module abstx_ctrl #(
  parameter int unsigned XFER_TMO_CYC = `ABSTX_XFER_TMO_CYC,
  parameter int unsigned REQ_TMO_CYC  = `ABSTX_REQ_TMO_CYC,
  parameter int unsigned RTS_TMO_CYC  = `ABSTX_RTS_TMO_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        positioning_done_bit0,
  input  wire logic        zero_speed_bit1,
  input  wire logic        ready_to_send,
  input  wire logic        fault_output,
  input  wire logic        forced_stop_input,
  input  wire logic        rev_tick,
  output logic             drive_enable_request,
  output logic             transfer_mode,
  output logic             data_request,
  output logic             alarm_reset,
  output logic             brake_release,
  output logic             deviation_clear,
  output logic             motion_enable,
  output logic             torque_limit_enable,
  output logic             servo_alarm,
  output logic             comm_error,
  output logic             checksum_error
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [5:0] abstx_sum(input logic [31:0] d);
    logic [5:0] s;
    s = 6'h00;
    for (int i = 0; i < 16; i++) begin
      s = s + {4'h0, d[2*i +: 2]};
    end
    return s;
  endfunction

  function automatic logic abstx_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  abstx_pkg::abstx_state_t state_q;
  logic [`ABSTX_CTRL_W-1:0] ctrl_q;
  logic [31:0]              home_pos_q;
  logic [`ABSTX_EV_W-1:0]   mask_q;
  logic [`ABSTX_EV_W-1:0]   evt_q;
  logic [31:0]              pos_q;
  logic [31:0]              shift_q;
  logic [5:0]               csum_q;
  logic [4:0]               pair_q;
  logic [2:0]               fails_q;
  logic [1:0]               rev_q;
  logic [12:0]              clr_cnt_q;
  logic                     hstart_q;
  logic                     valid_q;
  logic                     inpos_q;
  logic                     zspd_q;
  logic                     tlim_q;
  logic                     den_q;
  logic                     mode_q;
  logic                     req_q;
  logic                     alarm_q;
  logic                     comm_q;
  logic                     csum_err_q;
  logic                     clr_q;
  logic                     move_q;
  logic                     tlen_q;
  logic                     brake_q;
  logic                     irq_q;
  logic                     arst_q;
  logic [31:0]              prdata_q;
  logic                     pready_q;
  logic                     pslverr_q;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire access   = psel && penable && pready_q;
  wire wr       = access && pwrite;
  wire rd       = access && !pwrite;
  wire sel_ctrl = abstx_hit(paddr, `ABSTX_OFF_CTRL);
  wire sel_stat = abstx_hit(paddr, `ABSTX_OFF_STAT);
  wire sel_pos  = abstx_hit(paddr, `ABSTX_OFF_POS);
  wire sel_home = abstx_hit(paddr, `ABSTX_OFF_HOME);
  wire sel_evt  = abstx_hit(paddr, `ABSTX_OFF_EVT);
  wire sel_mask = abstx_hit(paddr, `ABSTX_OFF_MASK);
  wire mapped   = sel_ctrl || sel_stat || sel_pos || sel_home || sel_evt || sel_mask;

  wire [`ABSTX_ST_W-1:0] stat_w = {rev_q == `ABSTX_REV_NEEDED, alarm_q, csum_err_q, comm_q,
                                    tlim_q, zspd_q, inpos_q, valid_q, mode_q};
  wire [31:0] rdata_w = sel_ctrl ? {26'h0, ctrl_q} :
                        sel_stat ? {23'h0, stat_w} :
                        sel_pos  ? pos_q :
                        sel_home ? home_pos_q :
                        sel_evt  ? {27'h0, evt_q} :
                        sel_mask ? {27'h0, mask_q} : 32'h0000_0000;

  // ---------------------------------------------------------------
  // Handshake decode
  // ---------------------------------------------------------------
  wire alarm_now  = fault_output || !forced_stop_input;
  wire den_d      = ctrl_q[`ABSTX_CTRL_DEN] && !alarm_now;
  wire start      = den_d && !den_q;
  wire t_xfer, t_req, t_rts;
  wire timeout    = t_xfer || t_req || t_rts;
  wire in_xfer    = state_q == abstx_pkg::ABSTX_WAIT_RDY || state_q == abstx_pkg::ABSTX_REQ ||
                    state_q == abstx_pkg::ABSTX_ACK;
  wire sum_ok     = abstx_sum(shift_q) == csum_q;
  wire ready_pos  = state_q == abstx_pkg::ABSTX_DONE && valid_q && !mode_q;
  wire hstart_w   = ctrl_q[`ABSTX_CTRL_HSTART];
  wire home_go    = ctrl_q[`ABSTX_CTRL_HMODE] && hstart_w && !hstart_q && ready_pos &&
                    rev_q == `ABSTX_REV_NEEDED && !move_q;
  wire clr_active = clr_cnt_q != 13'h0000;
  wire [`ABSTX_EV_W-1:0] ev_set;

  assign ev_set[`ABSTX_EV_DONE]  = state_q == abstx_pkg::ABSTX_CHECK && sum_ok;
  assign ev_set[`ABSTX_EV_COMM]  = in_xfer && timeout;
  assign ev_set[`ABSTX_EV_CSUM]  = state_q == abstx_pkg::ABSTX_CHECK && !sum_ok &&
                                   fails_q == `ABSTX_MAX_FAILS - 3'h1;
  assign ev_set[`ABSTX_EV_ALARM] = alarm_now && !alarm_q;
  assign ev_set[`ABSTX_EV_HOME]  = home_go;

  // ---------------------------------------------------------------
  // Watchdogs
  // ---------------------------------------------------------------
  abstx_tmo u_tmo_xfer (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (mode_q),
    .limit   (XFER_TMO_CYC),
    .expired (t_xfer)
  );

  abstx_tmo u_tmo_req (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (req_q && ready_to_send),
    .limit   (REQ_TMO_CYC),
    .expired (t_req)
  );

  abstx_tmo u_tmo_rts (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (mode_q && !ready_to_send),
    .limit   (RTS_TMO_CYC),
    .expired (t_rts)
  );

  // ---------------------------------------------------------------
  // APB slave and software registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      prdata_q  <= rdata_w;
      pslverr_q <= psel && penable && !pready_q && !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= `ABSTX_CTRL_RST;
      home_pos_q <= 32'h0000_0000;
      mask_q     <= `ABSTX_MASK_RST;
    end else begin
      if (wr && sel_ctrl) ctrl_q <= pwdata[`ABSTX_CTRL_W-1:0];
      if (wr && sel_home) home_pos_q <= pwdata;
      if (wr && sel_mask) mask_q <= pwdata[`ABSTX_EV_W-1:0];
    end
  end

  // Read clears only what it returned; a set beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= 5'h00;
      irq_q <= 1'b0;
    end else begin
      evt_q <= ((rd && sel_evt) ? (evt_q & ~prdata_q[`ABSTX_EV_W-1:0]) : evt_q) | ev_set;
      irq_q <= |(evt_q & mask_q);
    end
  end

  // ---------------------------------------------------------------
  // Transfer sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= abstx_pkg::ABSTX_IDLE;
      mode_q     <= 1'b0;
      req_q      <= 1'b0;
      shift_q    <= 32'h0000_0000;
      csum_q     <= 6'h00;
      pair_q     <= 5'h00;
      fails_q    <= 3'h0;
      valid_q    <= 1'b0;
      comm_q     <= 1'b0;
      csum_err_q <= 1'b0;
      pos_q      <= 32'h0000_0000;
    end else if (!den_d) begin
      // Dropping drive enable aborts and clears the link error
      state_q <= abstx_pkg::ABSTX_IDLE;
      mode_q  <= 1'b0;
      req_q   <= 1'b0;
      valid_q <= 1'b0;
      comm_q  <= 1'b0;
    end else if (in_xfer && timeout) begin
      state_q <= abstx_pkg::ABSTX_DONE;
      mode_q  <= 1'b0;
      req_q   <= 1'b0;
      comm_q  <= 1'b1;
    end else begin
      case (state_q)
        abstx_pkg::ABSTX_IDLE: begin
          if (start) begin
            state_q    <= abstx_pkg::ABSTX_WAIT_RDY;
            mode_q     <= 1'b1;
            pair_q     <= 5'h00;
            fails_q    <= 3'h0;
            csum_err_q <= 1'b0;
          end
        end
        abstx_pkg::ABSTX_WAIT_RDY: begin
          if (ready_to_send) begin
            state_q <= abstx_pkg::ABSTX_REQ;
            req_q   <= 1'b1;
          end
        end
        abstx_pkg::ABSTX_REQ: begin
          if (!ready_to_send) begin
            state_q <= abstx_pkg::ABSTX_ACK;
            req_q   <= 1'b0;
            if (pair_q < 5'h10) begin
              shift_q <= {zero_speed_bit1, positioning_done_bit0, shift_q[31:2]};
            end else begin
              csum_q <= {zero_speed_bit1, positioning_done_bit0, csum_q[5:2]};
            end
          end
        end
        abstx_pkg::ABSTX_ACK: begin
          if (ready_to_send) begin
            if (pair_q == `ABSTX_LAST_PAIR) begin
              state_q <= abstx_pkg::ABSTX_CHECK;
            end else begin
              state_q <= abstx_pkg::ABSTX_REQ;
              pair_q  <= pair_q + 5'h01;
              req_q   <= 1'b1;
            end
          end
        end
        abstx_pkg::ABSTX_CHECK: begin
          mode_q <= 1'b0;
          if (sum_ok) begin
            state_q <= abstx_pkg::ABSTX_DONE;
            pos_q   <= shift_q;
            valid_q <= 1'b1;
            fails_q <= 3'h0;
          end else if (fails_q == `ABSTX_MAX_FAILS - 3'h1) begin
            state_q    <= abstx_pkg::ABSTX_DONE;
            csum_err_q <= 1'b1;
          end else begin
            state_q <= abstx_pkg::ABSTX_RETRY;
            fails_q <= fails_q + 3'h1;
          end
        end
        abstx_pkg::ABSTX_RETRY: begin
          // Mode low for one cycle tells the amplifier to start over
          state_q <= abstx_pkg::ABSTX_WAIT_RDY;
          mode_q  <= 1'b1;
          pair_q  <= 5'h00;
        end
        abstx_pkg::ABSTX_DONE: begin
          if (home_go) begin
            pos_q <= home_pos_q;
          end
        end
        default: begin
          state_q <= abstx_pkg::ABSTX_IDLE;
          mode_q  <= 1'b0;
          req_q   <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Home return, interlocks and status
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rev_q     <= 2'h0;
      hstart_q  <= 1'b0;
      clr_cnt_q <= 13'h0000;
      clr_q     <= 1'b0;
    end else begin
      if (rev_tick && rev_q != `ABSTX_REV_NEEDED) rev_q <= rev_q + 2'h1;
      hstart_q <= hstart_w;
      if (home_go) begin
        clr_cnt_q <= 13'(`ABSTX_CLR_CYC);
      end else if (clr_active) begin
        clr_cnt_q <= clr_cnt_q - 13'h0001;
      end
      clr_q <= home_go || (clr_active && clr_cnt_q != 13'h0001);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      den_q   <= 1'b0;
      alarm_q <= 1'b0;
      arst_q  <= 1'b0;
      move_q  <= 1'b0;
      tlen_q  <= 1'b0;
      brake_q <= 1'b0;
    end else begin
      den_q   <= den_d;
      alarm_q <= alarm_now;
      arst_q  <= ctrl_q[`ABSTX_CTRL_ARST];
      move_q  <= ctrl_q[`ABSTX_CTRL_MOVE] && ready_pos && !clr_active;
      tlen_q  <= ctrl_q[`ABSTX_CTRL_TLIM] && ready_pos;
      brake_q <= den_d && ready_pos;
    end
  end

  // Shared lines carry data while the mode is on, so status is frozen then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inpos_q <= 1'b0;
      zspd_q  <= 1'b0;
      tlim_q  <= 1'b0;
    end else if (!mode_q) begin
      inpos_q <= positioning_done_bit0;
      zspd_q  <= zero_speed_bit1;
      tlim_q  <= ready_to_send;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata               = prdata_q;
  assign pready               = pready_q;
  assign pslverr              = pslverr_q;
  assign irq                  = irq_q;
  assign drive_enable_request = den_q;
  assign transfer_mode        = mode_q;
  assign data_request         = req_q;
  assign alarm_reset          = arst_q;
  assign brake_release        = brake_q;
  assign deviation_clear      = clr_q;
  assign motion_enable        = move_q;
  assign torque_limit_enable  = tlen_q;
  assign servo_alarm          = alarm_q;
  assign comm_error           = comm_q;
  assign checksum_error       = csum_err_q;
endmodule

// ==== verification/abstx_amp_model.sv ====
`timescale 1ns/1ps
module abstx_amp_model #(
  // Lowest digit of the function select; 1 makes the brake interlock valid
  parameter logic [3:0] FUNCTION_SELECT_PARAM = 4'h1
) (
  input  wire logic        pclk,
  input  wire logic        drive_enable_request,
  input  wire logic        transfer_mode,
  input  wire logic        data_request,
  input  wire logic [31:0] pos_val,
  input  wire logic [2:0]  fault,
  input  wire logic [2:0]  stat,
  output logic             positioning_done_bit0,
  output logic             zero_speed_bit1,
  output logic             ready_to_send,
  output logic             brake_interlock
);
  // Fault 1 stalls ready low, 2 ignores requests, 3 spoils the sum, 4 answers slowly
  logic [4:0] k_q;
  logic [5:0] w_q;
  logic [5:0] sum_w;
  logic       req_q;
  logic       rts_w;
  logic [1:0] pair_w;
  always_comb begin
    sum_w = 6'h00;
    for (int i = 0; i < 16; i++) sum_w = sum_w + 6'(pos_val[2*i +: 2]);
    if (fault == 3'h3) sum_w = ~sum_w;
    pair_w = (k_q < 5'h10) ? pos_val[2*k_q +: 2] : sum_w[2*(k_q-5'h10) +: 2];
  end
  assign rts_w = (fault == 3'h2) || (fault != 3'h1 && !data_request && w_q >= (fault == 3'h4 ? 6'h14 : 6'h00));
  // Idle data lines toggle so a stale sample cannot pass
  assign ready_to_send = transfer_mode ? rts_w : stat[2];
  assign {zero_speed_bit1, positioning_done_bit0} = !transfer_mode ? stat[1:0] : data_request ? pair_w : ~pair_w;
  assign brake_interlock = (FUNCTION_SELECT_PARAM == 4'h1) && drive_enable_request && !transfer_mode;
  always_ff @(posedge pclk) begin
    req_q <= data_request;
    w_q <= (data_request || !transfer_mode) ? 6'h00 : w_q + {5'h00, w_q != 6'h3f};
    if (!transfer_mode)
      k_q <= 5'h00;
    else if (req_q && !data_request)
      k_q <= k_q + 5'h01;
  end
endmodule

// ==== verification/abstx_properties.sv ====
`timescale 1ns/1ps
module abstx_properties #(
  parameter int unsigned XFER_TMO_CYC = 200,
  parameter int unsigned REQ_TMO_CYC  = 50,
  parameter int unsigned RTS_TMO_CYC  = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic transfer_mode,
  input wire logic data_request,
  input wire logic ready_to_send,
  input wire logic drive_enable_request,
  input wire logic motion_enable,
  input wire logic torque_limit_enable,
  input wire logic deviation_clear,
  input wire logic servo_alarm,
  input wire logic fault_output,
  input wire logic forced_stop_input
);
  // Wait lengths; slack of a few cycles covers reaction latency
  logic [31:0] xfer_q, req_q, rts_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_q <= 32'h0;
      req_q <= 32'h0;
      rts_q <= 32'h0;
    end else begin
      xfer_q <= transfer_mode ? xfer_q + 32'h1 : 32'h0;
      req_q <= (data_request && ready_to_send) ? req_q + 32'h1 : 32'h0;
      rts_q <= (transfer_mode && !ready_to_send) ? rts_q + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_XFER_TMO: assert property (xfer_q <= XFER_TMO_CYC + 4)
    else $error("transfer mode held too long");
  AST_REQ_TMO: assert property (req_q <= REQ_TMO_CYC + 4)
    else $error("request held too long");
  AST_RTS_TMO: assert property (rts_q <= RTS_TMO_CYC + 4)
    else $error("ready low too long");
  AST_NO_MOTION: assert property (transfer_mode |-> !motion_enable)
    else $error("motion during transfer");
  AST_NO_TLIM: assert property (transfer_mode |-> !torque_limit_enable)
    else $error("torque limit during transfer");
  AST_CLEAR: assert property ($rose(deviation_clear) |-> !transfer_mode ##1 deviation_clear[*8])
    else $error("clear pulse wrong");
  AST_ALARM: assert property (fault_output || !forced_stop_input |=> servo_alarm && !drive_enable_request)
    else $error("alarm not reported");
  AST_START: assert property ($rose(drive_enable_request) |-> ##[0:1] transfer_mode)
    else $error("no transfer at enable");
endmodule
bind abstx_ctrl abstx_properties #(.XFER_TMO_CYC(XFER_TMO_CYC), .REQ_TMO_CYC(REQ_TMO_CYC),
  .RTS_TMO_CYC(RTS_TMO_CYC)) i_abstx_properties (.*);

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, pos_val = 32'h0, prdata, rd, home_v;
  logic [2:0] fault = 3'h0, stat = 3'h0;
  logic fault_output = 1'b0, forced_stop_input = 1'b1, rev_tick = 1'b0, err;
  logic pready, pslverr, irq, positioning_done_bit0, zero_speed_bit1, ready_to_send;
  logic drive_enable_request, transfer_mode, data_request, alarm_reset, brake_release;
  logic deviation_clear, motion_enable, torque_limit_enable, servo_alarm, comm_error, checksum_error;
  logic brake_interlock;
  int fails = 0, comparisons = 0, cyc = 0, starts = 0, clr_len = 0, n;
  logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
  abstx_ctrl #(.XFER_TMO_CYC(200), .REQ_TMO_CYC(50), .RTS_TMO_CYC(50)) i_abstx_ctrl (.*);
  abstx_amp_model i_abstx_amp_model (.*);
  always #12.5 pclk = ~pclk;
  always @(posedge transfer_mode) starts++;
  always @(posedge pclk) begin
    clr_len <= clr_len + int'(deviation_clear === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Drop and raise drive enable, then wait for success or an error flag
  task automatic den_cycle(input logic [2:0] f);
    apb(1'b1, 8'h00, 32'h0);
    fault <= f;
    pos_val <= $urandom;
    starts = 0;
    apb(1'b1, 8'h00, 32'h1);
    wait (transfer_mode === 1'b1);
    repeat (2) @(posedge pclk);
    wait (brake_release === 1'b1 || comm_error === 1'b1 || checksum_error === 1'b1);
    repeat (4) @(posedge pclk);
  endtask
  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h426ab0ac));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b1, 8'h18, 32'h5);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, 8'h14, 32'h1f);
    for (n = 0; n < 3; n++) begin
      stat <= 3'($urandom);
      den_cycle(3'h0);
      chk("brake", 32'h3, {brake_release, brake_interlock});
      apb(1'b0, 8'h08, 32'h0);
      chk("position", pos_val, rd);
      apb(1'b0, 8'h04, 32'h0);
      chk("status", {27'h0, stat, 2'b10}, rd);
      apb(1'b0, 8'h10, 32'h0);
      chk("done event", 32'h1, rd);
      apb(1'b1, 8'h00, 32'h31);
      repeat (3) @(posedge pclk);
      chk("motion irq", 32'h3, {irq, motion_enable, torque_limit_enable});
      apb(1'b1, 8'h00, 32'h1);
    end
    home_v = $urandom;
    apb(1'b1, 8'h0c, home_v);
    for (n = 0; n < 3; n++) begin
      apb(1'b1, 8'h00, 32'h3);
      apb(1'b1, 8'h00, 32'h7);
      repeat (3) @(posedge pclk);
      chk("home clear", {31'h0, n == 2}, {31'h0, deviation_clear});
      rev_tick <= 1'b1;
      @(posedge pclk);
      rev_tick <= 1'b0;
    end
    wait (deviation_clear === 1'b0);
    // Let the counter take its last sample first
    @(posedge pclk);
    chk("clear length", 32'hfa0, clr_len);
    apb(1'b0, 8'h08, 32'h0);
    chk("home pos", home_v, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("home event", 32'h10, rd);
    apb(1'b1, 8'h14, 32'h0);
    for (n = 0; n < 4; n++) begin
      den_cycle(codes[n]);
      apb(1'b0, 8'h10, 32'h0);
      chk("fault event", codes[n] == 3'h3 ? 32'h4 : 32'h2, rd);
      chk("fault flags", codes[n] == 3'h3 ? 32'h4 : 32'h2, {checksum_error, comm_error, irq});
      if (codes[n] == 3'h3)
        chk("attempts", 32'h4, starts);
    end
    fault <= 3'h0;
    apb(1'b1, 8'h14, 32'h1f);
    for (n = 0; n < 2; n++) begin
      apb(1'b0, 8'h10, 32'h0);
      fault_output <= n == 0;
      forced_stop_input <= n == 0;
      repeat (3) @(posedge pclk);
      chk("alarm", 32'h5, {servo_alarm, drive_enable_request, irq});
      apb(1'b0, 8'h10, 32'h0);
      chk("alarm event", 32'h8, rd);
      apb(1'b1, 8'h00, 32'h9);
      repeat (2) @(posedge pclk);
      chk("alarm reset", 32'h1, {31'h0, alarm_reset});
      apb(1'b1, 8'h00, 32'h1);
      fault_output <= 1'b0;
      forced_stop_input <= 1'b1;
      starts = 0;
      wait (brake_release === 1'b1);
      chk("restart", 32'h1, starts);
    end
    conclude();
  end
endmodule
